/* rtl/stpi_pkg.sv */
package stpi_pkg;

    // Step resolution switch setting
    typedef enum logic [1:0] {
        STPI_RES_500_E = 2'b00,
        STPI_RES_1000_E = 2'b01,
        STPI_RES_5000_E = 2'b10,
        STPI_RES_10000_E = 2'b11
    } stpi_res_t;

    // Complete state of the controller
    typedef struct packed {
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic step_d;
        logic ready;
        logic step_p;
        logic [13:0] ring;
        logic [16:0] still_cnt;
        logic halted;
        logic [7:0] pwm_cnt;
        logic [8:0] pwm_hi;
        logic [8:0] duty;
        logic [8:0] cur;
        logic ready_low_n;
        logic ready_plc;
        logic ring_zero;
    } stpi_state_t;

endpackage

/* rtl/stpi_regs.svh */
`ifndef STPI_REGS_SVH
`define STPI_REGS_SVH

// Positions inside the synchroniser vector
`define STPI_IN_STEP 0
`define STPI_IN_DIR 1
`define STPI_IN_EN 2
`define STPI_IN_EN24 3
`define STPI_IN_GATE 4
`define STPI_IN_PWM 5
`define STPI_IN_RED 6
`define STPI_IN_FLTN 7
`define STPI_IN_SEL0 8
`define STPI_IN_SEL1 9
`define STPI_IN_W 10

// Reset values
`define STPI_RING_RST 14'h0000
`define STPI_SYNC_RST 10'h000

// Steps per revolution, stored as modulus minus one
`define STPI_RES_500 14'h01F3
`define STPI_RES_1000 14'h03E7
`define STPI_RES_5000 14'h1387
`define STPI_RES_10000 14'h270F

// Current reduction at standstill, percent
`define STPI_RED_PCT 60
`define STPI_FULL_PCT 100

// Clock and timing
`define STPI_CLK_MHZ 100
`define STPI_STILL_US 1000
`define STPI_STILL_CYC (`STPI_STILL_US * `STPI_CLK_MHZ)

// PWM measurement window, cycles (full current = window)
`define STPI_PWM_WIN 9'h100

`endif

/* rtl/stpi_top.sv */
// Contract
// - Each accepted step clock pulse moves the ring counter exactly one step.
// - Phase current level follows PWM input duty, from zero to full.
// - Step pulses are accepted only while the pulse gate input enables them.
// - The 24 V amplifier enable acts the same as the pulse-side enable.
// - A dedicated output flags the ring counter at its zero position.
// - Ring zero, two readiness outputs (one active low), standstill output.
// - Direction input selects forward or backward ring counting.
// - Step on rising edge only when ready and gate energized.
// - With reduction selected, current drops to sixty percent at standstill.
// - Resolution of 500, 1000, 5000 or 10000 steps scales the ring.
`timescale 1ns/1ps
`default_nettype none
`include "stpi_regs.svh"

module stpi_top
    import stpi_pkg::*;
#(
    parameter int STILL_CYC = `STPI_STILL_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_step_clk,
    input wire logic i_dir,
    input wire logic i_amp_en,
    input wire logic i_amp_en_24,
    input wire logic i_gate_on,
    input wire logic i_pwm,
    input wire logic i_cur_reduce,
    input wire logic i_fault_n,
    input wire logic [1:0] i_step_sel,
    output logic o_ready_low_out_n,
    output logic o_ready_plc_out,
    output logic o_motor_halted_out,
    output logic o_ring_zero,
    output logic [13:0] o_ring_pos,
    output logic [8:0] o_phase_cur
);

    // Last ring position for a resolution setting
    function automatic logic [13:0] ring_top(input logic [1:0] sel);
        case (stpi_res_t'(sel))
            STPI_RES_500_E: ring_top = `STPI_RES_500;
            STPI_RES_1000_E: ring_top = `STPI_RES_1000;
            STPI_RES_5000_E: ring_top = `STPI_RES_5000;
            STPI_RES_10000_E: ring_top = `STPI_RES_10000;
            default: ring_top = `STPI_RES_10000;
        endcase
    endfunction

    // Percentage of a current level
    function automatic logic [8:0] pct_of(input logic [8:0] lvl, input int pct);
        pct_of = 9'((32'(lvl) * pct) / `STPI_FULL_PCT);
    endfunction

    stpi_state_t s_ff;
    stpi_state_t nxt_s;
    logic [9:0] in_vec;
    logic [13:0] top;
    logic step_edge;
    logic accept;

    assign in_vec = {i_step_sel, i_fault_n, i_cur_reduce, i_pwm, i_gate_on,
                     i_amp_en_24, i_amp_en, i_dir, i_step_clk};
    assign top = ring_top(s_ff.sync2[`STPI_IN_SEL1:`STPI_IN_SEL0]);
    // rising edge on synchronised step clock
    assign step_edge = s_ff.sync2[`STPI_IN_STEP] && !s_ff.step_d;
    // gate and readiness qualify the edge
    assign accept = step_edge && s_ff.ready && s_ff.sync2[`STPI_IN_GATE];

    // Next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.sync1 = in_vec;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.step_d = s_ff.sync2[`STPI_IN_STEP];
        // either enable input enables the amplifier
        nxt_s.ready = (s_ff.sync2[`STPI_IN_EN] || s_ff.sync2[`STPI_IN_EN24])
                      && s_ff.sync2[`STPI_IN_FLTN];
        nxt_s.step_p = accept;
        if (accept) begin
            if (s_ff.sync2[`STPI_IN_DIR]) begin
                nxt_s.ring = (s_ff.ring >= top) ? 14'h0000 : s_ff.ring + 14'h0001;
            end else begin
                nxt_s.ring = (s_ff.ring == 14'h0000 || s_ff.ring > top) ? top
                             : s_ff.ring - 14'h0001;
            end
        end else if (s_ff.ring > top) begin
            // resolution change folds ring back into range
            nxt_s.ring = `STPI_RING_RST;
        end
        // Standstill timer restarts on every step
        if (accept) begin
            nxt_s.still_cnt = 17'h00000;
            nxt_s.halted = 1'b0;
        end else if (32'(s_ff.still_cnt) >= STILL_CYC - 1) begin
            nxt_s.halted = 1'b1;
        end else begin
            nxt_s.still_cnt = s_ff.still_cnt + 17'h00001;
        end
        // count PWM high cycles over a fixed window
        nxt_s.pwm_cnt = s_ff.pwm_cnt + 8'h01;
        if (s_ff.pwm_cnt == 8'hFF) begin
            nxt_s.duty = s_ff.pwm_hi + {8'h00, s_ff.sync2[`STPI_IN_PWM]};
            nxt_s.pwm_hi = 9'h000;
        end else begin
            nxt_s.pwm_hi = s_ff.pwm_hi + {8'h00, s_ff.sync2[`STPI_IN_PWM]};
        end
        if (s_ff.halted && s_ff.sync2[`STPI_IN_RED]) begin
            nxt_s.cur = pct_of(s_ff.duty, `STPI_RED_PCT);
        end else begin
            nxt_s.cur = s_ff.duty;
        end
        nxt_s.ready_low_n = !s_ff.ready;
        nxt_s.ready_plc = s_ff.ready;
        nxt_s.ring_zero = (nxt_s.ring == 14'h0000);
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_ff <= '0;
            s_ff.sync1 <= `STPI_SYNC_RST;
            s_ff.sync2 <= `STPI_SYNC_RST;
            s_ff.ring <= `STPI_RING_RST;
            s_ff.ready_low_n <= 1'b1;
            s_ff.ring_zero <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from flops
    assign o_ready_low_out_n = s_ff.ready_low_n;
    assign o_ready_plc_out = s_ff.ready_plc;
    assign o_motor_halted_out = s_ff.halted;
    assign o_ring_zero = s_ff.ring_zero;
    assign o_ring_pos = s_ff.ring;
    assign o_phase_cur = s_ff.cur;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_step_gated: assert property (step_edge && !s_ff.sync2[`STPI_IN_GATE]
        |=> $stable(s_ff.ring)) else $error("ring moved with gate closed");
    chk_step_ready: assert property (step_edge && !s_ff.ready
        |=> $stable(s_ff.ring)) else $error("ring moved while not ready");
    chk_step_fwd: assert property (accept && s_ff.sync2[`STPI_IN_DIR] && s_ff.ring < top
        |=> s_ff.ring == $past(s_ff.ring) + 14'h0001) else $error("forward step wrong");
    chk_step_back: assert property (accept && !s_ff.sync2[`STPI_IN_DIR]
        && s_ff.ring != 14'h0000 && s_ff.ring <= top
        |=> s_ff.ring == $past(s_ff.ring) - 14'h0001) else $error("backward step wrong");
    chk_ring_range: assert property (##1 s_ff.ring <= top || $changed(top))
        else $error("ring beyond resolution");
    chk_zero_flag: assert property (o_ring_zero == (o_ring_pos == 14'h0000))
        else $error("zero flag mismatch");
    chk_ready_pair: assert property (o_ready_low_out_n != o_ready_plc_out)
        else $error("readiness outputs disagree");
    chk_enable_equiv: assert property ($rose(s_ff.sync2[`STPI_IN_EN24])
        && s_ff.sync2[`STPI_IN_FLTN] ##1 s_ff.sync2[`STPI_IN_FLTN]
        |-> ##1 o_ready_plc_out) else $error("24 V enable ignored");
    chk_sync_delay: assert property (s_ff.sync2[`STPI_IN_GATE]
        == $past(i_gate_on, 2) || !$past(i_rst_n, 2)) else $error("sync depth wrong");
    chk_cur_reduce: assert property (s_ff.halted && s_ff.sync2[`STPI_IN_RED]
        |=> o_phase_cur == pct_of($past(s_ff.duty), `STPI_RED_PCT))
        else $error("reduced current wrong");
    chk_cur_full: assert property (!s_ff.halted
        |=> o_phase_cur == $past(s_ff.duty)) else $error("current not from duty");
    chk_halt_clear: assert property (accept |=> !o_motor_halted_out)
        else $error("halted after step");

    // Standstill flag after the quiet time
    chk_halt_set: assert property (!accept && 32'(s_ff.still_cnt) >= STILL_CYC - 1
        |=> o_motor_halted_out)
        else $error("standstill flag missing");

    // Readiness outputs trail the internal flag by one cycle
    chk_ready_follow: assert property (1'b1 |=> o_ready_plc_out == $past(s_ff.ready))
        else $error("ready output stale");
    chk_ready_low: assert property (1'b1 |=> o_ready_low_out_n == !$past(s_ff.ready))
        else $error("low ready output stale");

    // Either enable readies the amplifier, a fault blocks it
    chk_amp_any: assert property ((s_ff.sync2[`STPI_IN_EN] || s_ff.sync2[`STPI_IN_EN24])
        && s_ff.sync2[`STPI_IN_FLTN] |=> s_ff.ready)
        else $error("enable not honoured");
    chk_fault_block: assert property (!s_ff.sync2[`STPI_IN_FLTN]
        |=> !s_ff.ready)
        else $error("ready despite fault");

    // Wrap points of the ring in both senses
    chk_fwd_wrap: assert property (accept && s_ff.sync2[`STPI_IN_DIR]
        && s_ff.ring == top |=> s_ff.ring == 14'h0000)
        else $error("forward wrap wrong");
    chk_back_wrap: assert property (accept && !s_ff.sync2[`STPI_IN_DIR]
        && s_ff.ring == 14'h0000
        |=> s_ff.ring == $past(top))
        else $error("backward wrap wrong");

    // No movement without an accepted pulse, except the fold to zero when the ring is beyond top
    chk_idle_hold: assert property (!accept && s_ff.ring <= top
        |=> $stable(s_ff.ring))
        else $error("ring moved without step");
    chk_fold_zero: assert property (!accept && s_ff.ring > top
        |=> s_ff.ring == 14'h0000)
        else $error("ring not folded");

    // Step marker shows a move and clears standstill
    chk_step_moves: assert property (s_ff.step_p
        |-> $changed(s_ff.ring) && !o_motor_halted_out)
        else $error("step marker without move");

    // Current without reduction, and duty within full scale
    chk_cur_keep: assert property (s_ff.halted && !s_ff.sync2[`STPI_IN_RED]
        |=> o_phase_cur == $past(s_ff.duty))
        else $error("current reduced without option");
    chk_duty_range: assert property (s_ff.pwm_cnt == 8'hFF
        |=> s_ff.duty <= `STPI_PWM_WIN)
        else $error("duty beyond full scale");

    cov_step_fwd: cover property (accept && s_ff.sync2[`STPI_IN_DIR]);
    cov_step_back: cover property (accept && !s_ff.sync2[`STPI_IN_DIR]);
    cov_wrap_zero: cover property (accept ##1 o_ring_zero);
    cov_halted: cover property ($rose(o_motor_halted_out));
    cov_reduced: cover property (s_ff.halted && s_ff.sync2[`STPI_IN_RED]);

endmodule
`default_nettype wire

/* tb/stepper_pulse_interface_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module stepper_pulse_interface_test;
    import stpi_pkg::*;
    localparam int STILL = 50;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_amp_en = 1'b0;
    logic i_amp_en_24 = 1'b0;
    logic i_cur_reduce = 1'b0;
    logic i_fault_n = 1'b1;
    logic i_pwm = 1'b0;
    logic [1:0] i_step_sel = 2'b00;
    logic step_w, dir_w, gate_w, rdy_n, rdy, halted, zero;
    logic [13:0] pos;
    logic [8:0] cur;
    int error_cnt = 0;
    int n_compared = 0;
    int exp_pos = 0;
    int pwm_mode = 0;
    int top[4] = '{499, 999, 4999, 9999};
    stpi_master_model u_master (.i_clk(i_clk), .o_step_clk(step_w), .o_dir(dir_w),
        .o_gate_on(gate_w));
    stpi_top #(.STILL_CYC(STILL)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_step_clk(step_w),
        .i_dir(dir_w), .i_amp_en(i_amp_en), .i_amp_en_24(i_amp_en_24), .i_gate_on(gate_w),
        .i_pwm(i_pwm), .i_cur_reduce(i_cur_reduce), .i_fault_n(i_fault_n),
        .i_step_sel(i_step_sel), .o_ready_low_out_n(rdy_n), .o_ready_plc_out(rdy),
        .o_motor_halted_out(halted), .o_ring_zero(zero), .o_ring_pos(pos), .o_phase_cur(cur));
    // Clock and PWM source: low, high or toggling
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        #1 i_pwm = (pwm_mode == 2) ? ~i_pwm : (pwm_mode == 1);
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One step through the master, expected ring tracked here
    task automatic step(input logic d, input int hold);
        int sel;
        sel = i_step_sel;
        u_master.send_step(d, hold);
        tick(0);
        exp_pos = d ? ((exp_pos == top[sel]) ? 0 : exp_pos + 1)
                    : ((exp_pos == 0) ? top[sel] : exp_pos - 1);
        `CHK("ring_pos", 14'(exp_pos), pos)
        `CHK("ring_zero", exp_pos == 0, zero)
        `CHK("halted", 1'b0, halted)
    endtask
    task automatic t_ready();
        i_amp_en = 1'b1;
        tick(6);
        `CHK("ready_plc", 1'b1, rdy)
        `CHK("ready_low_n", 1'b0, rdy_n)
        i_amp_en = 1'b0;
        i_amp_en_24 = 1'b1;
        tick(6);
        `CHK("ready_24", 1'b1, rdy)
        i_fault_n = 1'b0;
        tick(6);
        `CHK("ready_off", 1'b1, rdy_n)
        `CHK("ready_plc_off", 1'b0, rdy)
        u_master.send_step(1'b1, 2);
        tick(0);
        `CHK("pos_not_ready", 14'(exp_pos), pos)
        i_fault_n = 1'b1;
        tick(6);
    endtask
    task automatic t_steps();
        for (int k = 0; k < 3; k++) step(1'b1, 2 + 2 * (k % 2));
        for (int k = 0; k < 3; k++) step(1'b0, 2);
        u_master.set_gate(1'b0);
        tick(3);
        u_master.send_step(1'b1, 2);
        tick(2);
        `CHK("pos_gated", 14'(exp_pos), pos)
        u_master.set_gate(1'b1);
        tick(3);
    endtask
    task automatic t_res();
        for (int s = 0; s < 4; s++) begin
            i_step_sel = 2'(s);
            tick(4);
            step(1'b0, 2);
            step(1'b1, 2);
        end
    endtask
    // Window is 256 cycles; toggling gives 128, steady high 256
    task automatic t_cur();
        pwm_mode = 1;
        tick(STILL + 600);
        `CHK("halted_set", 1'b1, halted)
        `CHK("cur_full", 9'h100, cur)
        i_cur_reduce = 1'b1;
        tick(600);
        `CHK("cur_full_red", 9'h099, cur)
        pwm_mode = 2;
        tick(600);
        `CHK("cur_half_red", 9'h04C, cur)
        i_cur_reduce = 1'b0;
        tick(600);
        `CHK("cur_half", 9'h080, cur)
        pwm_mode = 0;
        tick(600);
        `CHK("cur_none", 9'h000, cur)
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        tick(12);
        `CHK("rst_ready_n", 1'b1, rdy_n)
        `CHK("rst_zero", 1'b1, zero)
        `CHK("rst_pos", 14'h0000, pos)
        i_rst_n = 1'b1;
        t_ready();
        t_steps();
        t_res();
        t_cur();
        report_and_stop();
    end
endmodule
`default_nettype wire

/* tb/stpi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module stpi_master_model (
    input wire logic i_clk,
    output logic o_step_clk,
    output logic o_dir,
    output logic o_gate_on
);
    // Idle: step low, gate open
    initial begin
        o_step_clk = 1'b0;
        o_dir = 1'b1;
        o_gate_on = 1'b1;
    end
    task automatic set_gate(input logic g);
        @(posedge i_clk);
        #1 o_gate_on = g;
    endtask
    task automatic send_step(input logic d, input int hold);
        @(posedge i_clk);
        #1 o_dir = d;
        repeat (3) @(posedge i_clk);
        #1 o_step_clk = 1'b1;
        repeat (hold) @(posedge i_clk);
        #1 o_step_clk = 1'b0;
        repeat (hold) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire
